/* File: core/usb_dev_ctrl_map.vh */
// register map, field positions, reset values and timing counts of the
// usb device address and power control block
// assumes: included by bare name from design files under core/
`ifndef USB_DEV_CTRL_MAP_VH
`define USB_DEV_CTRL_MAP_VH
// ====================================================================
// register offsets
`define OFF_DEV_ADDR 3'h0
`define OFF_LINK_POWER 3'h1
`define OFF_IRQ_ENABLE 3'h2
`define OFF_IRQ_FLAGS 3'h3
`define OFF_EP_INDEX 3'h4
`define OFF_EP_STATUS 3'h5
// ====================================================================
// address register fields
`define ADDR_PENDING_BIT 7
`define ADDR_RESET 8'h00
// ====================================================================
// power register fields
`define PWR_ISO_BIT 7
`define PWR_INHIBIT_BIT 4
`define PWR_BUSRST_BIT 3
`define PWR_RESUME_BIT 2
`define PWR_SUSP_BIT 1
`define PWR_SUSPEND_DETECT_ENABLE_BIT 0
`define PWR_RESET 8'h10
// ====================================================================
// interrupt enable/flag fields
`define IRQ_SUSP_BIT 0
`define IRQ_RESUME_BIT 1
`define IRQ_RESET_BIT 2
`define IRQ_SOF_BIT 3
`define IRQ_EN_RESET 8'h00
`define IRQ_EN_BUSRST 8'h0E
`define EP_RESET 8'h00
// ====================================================================
// timing
`define CLK_HZ 20000000
`define AUTO_RESUME_US 10000
`endif

/* File: core/sync2.v */
// two flip-flop synchroniser for one level
// assumes: async active-low reset, single destination clock
module sync2 (
  input wire clk,
  input wire rst_n,
  input wire din,
  output reg dout
);
  reg stage1;
  // ====================================================================
  // first stage feeds only the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

/* File: core/rise_pulse.v */
// one-cycle pulse on the rising edge of a synchronised level
// assumes: input already in the clock domain
module rise_pulse (
  input wire clk,
  input wire rst_n,
  input wire level,
  output wire pulse
);
  reg last;
  // ====================================================================
  // previous value register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last <= 1'b0;
    end else begin
      last <= level;
    end
  end
  assign pulse = level & ~last;
endmodule

/* File: core/usb_device_address_and_power_control.v */
// usb device-level control: function address, bus reset, suspend,
// remote wakeup, iso hold, inhibit
// assumes: bus event levels come from the transceiver domain (synced here),
// token strobes come from the packet engine on core_clk
//
// Behaviour
// [R1] seven-bit function address in address register
// [R2] new address waits for transfer end
// [R3] bit 7 flags pending address update
// [R4] bus reset sets power bit 3
// [R5] bus reset clears address, flushes fifos
// [R6] bus reset clears endpoint registers, index
// [R7] bus reset enables non-suspend irqs, clears flags
// [R8] reset interrupt raised after bus reset
// [R9] writing bus reset bit resets function
// [R10] enter suspend when enabled and signalled
// [R11] suspend interrupt if enabled
// [R12] leave suspend on resume or reset
// [R13] wake events also wake the oscillator
// [R14] resume interrupt on bus resume
// [R15] drive resume while bit 2 set
// [R16] firmware ends resume after 10-15 ms
// [R17] iso mode holds packets until sof
// [R18] early iso in token gets zero-length
// [R19] function disabled until inhibit cleared
// [R20] inhibit sets only on resets
// [R21] firmware configures before clearing inhibit
// [R22] inhibited function ignores bus traffic
// [R23] match tokens on effective address only
//
// Our own choice: the strobed register port.
`include "usb_dev_ctrl_map.vh"
module usb_device_address_and_power_control #(
  parameter EP_COUNT = 3
) (
  input wire core_clk,
  input wire rst_n,
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdata,
  input wire busResetSeen,
  input wire busSuspendSeen,
  input wire busResumeSeen,
  input wire tokenValid,
  input wire [6:0] tokenAddr,
  input wire tokenIsIn,
  input wire tokenIsSof,
  input wire transferDone,
  input wire isoInEndpoint,
  input wire isoPacketLoaded,
  output wire tokenAccept,
  output wire sendZeroLength,
  output wire isoPacketRelease,
  output reg [EP_COUNT-1:0] fifoFlush,
  output wire driveResume,
  output wire oscWake,
  output wire linkEnabled,
  output wire irqSuspend,
  output wire irqResume,
  output wire irqReset,
  output reg [6:0] effectiveAddr
);
  // ====================================================================
  // storage
  reg [6:0] functionAddress;
  reg addrPending;
  reg isoSofHold;
  reg linkInhibit;
  reg busResetFlag;
  reg forceResume;
  reg suspendedStatus;
  reg suspendDetectEnable;
  reg [7:0] irqEnable;
  reg [7:0] irqFlags;
  reg [7:0] epIndex;
  reg [7:0] epStatus;
  reg isoHeld;
  reg softReset;
  wire bus_reset_flag_n;
  wire resetLvl;
  wire suspendLvl;
  wire resumeLvl;
  wire resetEvt;
  wire suspendEvt;
  wire resumeEvt;
  wire wrAddr;
  wire wrPower;
  wire wakeEvent;
  reg [7:0] next_rdata;

  // ====================================================================
  // soft reset: a write of 1 to the bus-reset bit pulses a local reset
  // one cycle long; it is combined with rst_n as an async reset so all
  // function registers, including inhibit, return to default
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      softReset <= 1'b0;
    end else begin
      softReset <= regWrite && regAddr == `OFF_LINK_POWER
        && regWdata[`PWR_BUSRST_BIT]; // R9
    end
  end
  assign bus_reset_flag_n = rst_n & ~softReset; // R9

  // ====================================================================
  // bus event levels arrive from the transceiver, synchronise them
  sync2 syncReset (.clk(core_clk), .rst_n(bus_reset_flag_n), .din(busResetSeen), .dout(resetLvl));
  sync2 syncSuspend (.clk(core_clk), .rst_n(bus_reset_flag_n), .din(busSuspendSeen),
    .dout(suspendLvl));
  sync2 syncResume (.clk(core_clk), .rst_n(bus_reset_flag_n), .din(busResumeSeen), .dout(resumeLvl));

  // inhibited function sees no bus events at all
  rise_pulse edgeReset (.clk(core_clk), .rst_n(bus_reset_flag_n), .level(resetLvl & ~linkInhibit),
    .pulse(resetEvt)); // R22
  rise_pulse edgeSuspend (.clk(core_clk), .rst_n(bus_reset_flag_n),
    .level(suspendLvl & ~linkInhibit), .pulse(suspendEvt)); // R22
  rise_pulse edgeResume (.clk(core_clk), .rst_n(bus_reset_flag_n), .level(resumeLvl & ~linkInhibit),
    .pulse(resumeEvt)); // R22

  assign wrAddr = regWrite && regAddr == `OFF_DEV_ADDR;
  assign wrPower = regWrite && regAddr == `OFF_LINK_POWER;
  // any of these ends suspend; the async resets clear it directly
  assign wakeEvent = resumeEvt | forceResume | resetEvt; // R12

  // ====================================================================
  // function address with deferred take-over
  always @(posedge core_clk or negedge bus_reset_flag_n) begin
    if (!bus_reset_flag_n) begin
      functionAddress <= 7'h00;
      effectiveAddr <= 7'h00;
      addrPending <= 1'b0;
    end else if (resetEvt) begin
      functionAddress <= 7'h00; // R5
      effectiveAddr <= 7'h00; // R5
      addrPending <= 1'b0;
    end else if (wrAddr) begin
      functionAddress <= regWdata[6:0]; // R1
      addrPending <= 1'b1; // R3
    end else if (addrPending && transferDone) begin
      effectiveAddr <= functionAddress; // R2
      addrPending <= 1'b0; // R3
    end
  end

  // ====================================================================
  // power register bits
  always @(posedge core_clk or negedge bus_reset_flag_n) begin
    if (!bus_reset_flag_n) begin
      isoSofHold <= 1'b0;
      linkInhibit <= 1'b1; // R19
      busResetFlag <= 1'b0;
      forceResume <= 1'b0;
      suspendDetectEnable <= 1'b0;
    end else begin
      if (wrPower) begin
        isoSofHold <= regWdata[`PWR_ISO_BIT];
        forceResume <= regWdata[`PWR_RESUME_BIT]; // R15
        suspendDetectEnable <= regWdata[`PWR_SUSPEND_DETECT_ENABLE_BIT];
        // only a clear lands here; writing 1 leaves it as is
        if (!regWdata[`PWR_INHIBIT_BIT]) begin
          linkInhibit <= 1'b0; // R20
        end
      end
      // flag reads as set after a detected reset; a read of the
      // power register clears it, unless a new reset arrives then
      if (resetEvt) begin
        busResetFlag <= 1'b1; // R4
      end else if (regRead && regAddr == `OFF_LINK_POWER) begin
        busResetFlag <= 1'b0;
      end
    end
  end

  // ====================================================================
  // suspend state
  always @(posedge core_clk or negedge bus_reset_flag_n) begin
    if (!bus_reset_flag_n) begin
      suspendedStatus <= 1'b0; // R12
    end else if (wakeEvent) begin
      suspendedStatus <= 1'b0; // R12
    end else if (suspendEvt && suspendDetectEnable) begin
      suspendedStatus <= 1'b1; // R10
    end
  end
  // oscillator wakes on the same events; an async reset clears suspend with no pulse
  assign oscWake = suspendedStatus & wakeEvent; // R13
  assign driveResume = forceResume; // R15

  // ====================================================================
  // interrupt enables and sticky flags; sets win over clears
  always @(posedge core_clk or negedge bus_reset_flag_n) begin
    if (!bus_reset_flag_n) begin
      irqEnable <= `IRQ_EN_RESET;
      irqFlags <= 8'h00;
    end else if (resetEvt) begin
      irqEnable <= `IRQ_EN_BUSRST; // R7
      // flags cleared, then the reset interrupt raised whatever the old enable
      irqFlags <= 8'h00 | (8'h01 << `IRQ_RESET_BIT); // R8
    end else begin
      if (regWrite && regAddr == `OFF_IRQ_ENABLE) begin
        irqEnable <= regWdata;
      end
      irqFlags <= (irqFlags & ~((regWrite && regAddr == `OFF_IRQ_FLAGS) ? regWdata : 8'h00))
        | {4'h0, 1'b0,
        resetEvt & irqEnable[`IRQ_RESET_BIT],
        resumeEvt & irqEnable[`IRQ_RESUME_BIT], // R14
        suspendEvt & suspendDetectEnable & irqEnable[`IRQ_SUSP_BIT]}; // R11
    end
  end
  assign irqSuspend = irqFlags[`IRQ_SUSP_BIT]; // R11
  assign irqResume = irqFlags[`IRQ_RESUME_BIT]; // R14
  assign irqReset = irqFlags[`IRQ_RESET_BIT]; // R8

  // ====================================================================
  // endpoint index/status and fifo flush
  always @(posedge core_clk or negedge bus_reset_flag_n) begin
    if (!bus_reset_flag_n) begin
      epIndex <= `EP_RESET;
      epStatus <= `EP_RESET;
      fifoFlush <= {EP_COUNT{1'b0}};
    end else if (resetEvt) begin
      epIndex <= `EP_RESET; // R6
      epStatus <= `EP_RESET; // R6
      fifoFlush <= {EP_COUNT{1'b1}}; // R5
    end else begin
      fifoFlush <= {EP_COUNT{1'b0}};
      if (regWrite && regAddr == `OFF_EP_INDEX) begin
        epIndex <= regWdata;
      end
      if (regWrite && regAddr == `OFF_EP_STATUS) begin
        epStatus <= regWdata;
      end
    end
  end

  // ====================================================================
  // iso hold: a loaded packet waits for the next sof in hold mode
  always @(posedge core_clk or negedge bus_reset_flag_n) begin
    if (!bus_reset_flag_n) begin
      isoHeld <= 1'b0;
    end else if (resetEvt || (tokenValid && tokenIsSof && !linkInhibit)) begin
      isoHeld <= 1'b0; // R17
    end else if (isoPacketLoaded && isoSofHold) begin
      isoHeld <= 1'b1; // R17
    end
  end
  assign isoPacketRelease = isoPacketLoaded ? ~isoSofHold : 1'b0;

  // ====================================================================
  // token matching
  assign linkEnabled = ~linkInhibit; // R19
  // sof is broadcast, everything else must hit the effective address
  assign tokenAccept = tokenValid && !linkInhibit
    && (tokenIsSof || tokenAddr == effectiveAddr); // R23
  assign sendZeroLength = tokenAccept && tokenIsIn && isoInEndpoint
    && isoSofHold && isoHeld; // R18

  // ====================================================================
  // register read mux, data one cycle after strobe
  always @* begin
    case (regAddr)
      `OFF_DEV_ADDR: next_rdata = {addrPending, functionAddress};
      `OFF_LINK_POWER: next_rdata = {isoSofHold, 2'b00, linkInhibit, busResetFlag,
        forceResume, suspendedStatus, suspendDetectEnable};
      `OFF_IRQ_ENABLE: next_rdata = irqEnable;
      `OFF_IRQ_FLAGS: next_rdata = irqFlags;
      `OFF_EP_INDEX: next_rdata = epIndex;
      `OFF_EP_STATUS: next_rdata = epStatus;
      default: next_rdata = 8'h00;
    endcase
  end
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      regRdata <= next_rdata;
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule

/* File: tb/usb_dev_ctrl_props.sv */
// concurrent checks on the ports of the usb device control block
// assumes: bound to the top module, one clock, async active-low reset
module usb_dev_ctrl_props #(
  parameter EP_COUNT = 3
) (
  input wire core_clk,
  input wire rst_n,
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdata,
  input wire busResetSeen,
  input wire tokenValid,
  input wire [6:0] tokenAddr,
  input wire tokenIsIn,
  input wire tokenIsSof,
  input wire transferDone,
  input wire isoInEndpoint,
  input wire isoPacketLoaded,
  input wire tokenAccept,
  input wire sendZeroLength,
  input wire isoPacketRelease,
  input wire [EP_COUNT-1:0] fifoFlush,
  input wire driveResume,
  input wire linkEnabled,
  input wire irqReset,
  input wire [6:0] effectiveAddr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==================================================================
  // helper decodes of power and address register accesses and of bus reset
  wire softWr = regWrite && regAddr == 3'h1 && regWdata[3];
  wire pwrWr = regWrite && regAddr == 3'h1 && !regWdata[3];
  sequence s_addrWr; regWrite && regAddr == 3'h0 && !transferDone; endsequence
  sequence s_addrRd; regRead && regAddr == 3'h0 && !transferDone; endsequence
  sequence s_busRst; $rose(busResetSeen) && linkEnabled; endsequence
  // ==================================================================
  // properties
  property p_accept;
    tokenAccept |-> tokenValid && linkEnabled && (tokenIsSof || tokenAddr == effectiveAddr);
  endproperty
  property p_zeroLen; sendZeroLength |-> tokenAccept && tokenIsIn && isoInEndpoint; endproperty
  property p_release; isoPacketRelease |-> isoPacketLoaded; endproperty
  property p_drive; pwrWr |=> driveResume == $past(regWdata[2]); endproperty
  // inhibit may only come back through the soft reset a few cycles on
  property p_inhibit;
    $fell(linkEnabled) |-> $past(softWr) || $past(softWr, 2) || $past(softWr, 3);
  endproperty
  property p_flush; s_busRst |-> ##[1:6] fifoFlush == {EP_COUNT{1'b1}}; endproperty
  property p_irqReset; s_busRst |-> ##[1:6] irqReset; endproperty
  property p_addrHold;
    $changed(effectiveAddr) |-> $past(transferDone) || effectiveAddr == 7'h00;
  endproperty
  // firmware leaves one idle cycle between a write and the read back
  property p_pending; s_addrWr ##1 !transferDone ##1 s_addrRd |=> regRdata[7]; endproperty
  a_accept: assert property (p_accept) else $error("token accepted wrongly");
  a_zeroLen: assert property (p_zeroLen) else $error("zero-length on wrong token");
  a_release: assert property (p_release) else $error("iso release without load");
  a_drive: assert property (p_drive) else $error("resume drive mismatch");
  a_inhibit: assert property (p_inhibit) else $error("inhibit set without reset");
  a_flush: assert property (p_flush) else $error("no flush after bus reset");
  a_irqReset: assert property (p_irqReset) else $error("no reset interrupt");
  a_addrHold: assert property (p_addrHold) else $error("address changed early");
  a_pending: assert property (p_pending) else $error("pending flag not set");
endmodule
bind usb_device_address_and_power_control usb_dev_ctrl_props #(.EP_COUNT(EP_COUNT)) chk_u (.*);

/* File: tb/usb_host_model.sv */
// behavioural usb host: bus reset, suspend, resume levels and tokens
// assumes: caller invokes tasks from the testbench, core_clk free running
module usb_host_model (
  input wire core_clk,
  input wire tokenAccept,
  input wire sendZeroLength,
  output logic busResetSeen,
  output logic busSuspendSeen,
  output logic busResumeSeen,
  output logic tokenValid,
  output logic [6:0] tokenAddr,
  output logic tokenIsIn,
  output logic tokenIsSof
);
  timeunit 1ns;
  timeprecision 1ns;
  logic gotAccept;
  logic gotZero;
  // ==================================================================
  // idle bus at start
  initial begin
    {busResetSeen, busSuspendSeen, busResumeSeen} = 3'h0;
    {tokenValid, tokenIsIn, tokenIsSof} = 3'h0;
    tokenAddr = 7'h7F;
  end
  // line signalling, shortened: only the edge matters to the device
  task signal(input int kind);
    @(posedge core_clk);
    busResetSeen <= (kind == 0);
    busSuspendSeen <= (kind == 1);
    busResumeSeen <= (kind == 2);
    repeat (4) @(posedge core_clk);
    {busResetSeen, busSuspendSeen, busResumeSeen} <= 3'h0;
  endtask
  // one-cycle token; address inverted afterwards so stale values never match
  task token(input logic [6:0] a, input logic isIn, input logic isSof);
    @(posedge core_clk);
    tokenValid <= 1'b1;
    tokenAddr <= a;
    tokenIsIn <= isIn;
    tokenIsSof <= isSof;
    @(negedge core_clk);
    gotAccept = tokenAccept;
    gotZero = sendZeroLength;
    @(posedge core_clk);
    tokenValid <= 1'b0;
    tokenAddr <= ~a;
    {tokenIsIn, tokenIsSof} <= 2'h0;
  endtask
endmodule

/* File: tb/tb_top.sv */
// register-level testbench of the usb device control block
// assumes: host model on the bus side, bench acts as firmware and packet engine
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst_n, regWrite, regRead, busResetSeen, busSuspendSeen, busResumeSeen;
  logic tokenValid, tokenIsIn, tokenIsSof, transferDone, isoInEndpoint, isoPacketLoaded;
  logic tokenAccept, sendZeroLength, isoPacketRelease, driveResume, oscWake, linkEnabled;
  logic irqSuspend, irqResume, irqReset, flushSeen = 1'b0, wakeSeen = 1'b0;
  logic [2:0] regAddr, fifoFlush;
  logic [7:0] regWdata, regRdata;
  logic [6:0] tokenAddr, effectiveAddr;
  int err_total = 0, checks_done = 0;
  usb_device_address_and_power_control #(.EP_COUNT(3)) dut_u (.*);
  usb_host_model host_u (.*);
  // ==================================================================
  // clock, pulse catchers and watchdog
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (fifoFlush === 3'h7) flushSeen <= 1'b1;
    if (oscWake === 1'b1) wakeSeen <= 1'b1;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    conclude;
  end
  // ==================================================================
  // shared tasks
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(negedge core_clk);
    chk(regRdata, exp);
  endtask
  task tok(input logic [6:0] a, input logic isIn, input logic isSof, input logic acc,
           input logic zero);
    host_u.token(a, isIn, isSof);
    chk({7'h00, host_u.gotAccept}, {7'h00, acc});
    chk({7'h00, host_u.gotZero}, {7'h00, zero});
  endtask
  // one-cycle strobe on a packet-engine line; comb outputs looked at mid-cycle
  task loadIso(input logic expRel);
    @(posedge core_clk);
    isoPacketLoaded <= 1'b1;
    @(negedge core_clk);
    chk({7'h00, isoPacketRelease}, {7'h00, expRel});
    @(posedge core_clk);
    isoPacketLoaded <= 1'b0;
  endtask
  task conclude;
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==================================================================
  // main sequence
  initial begin
    {rst_n, regWrite, regRead, transferDone, isoInEndpoint, isoPacketLoaded} = 6'h00;
    regAddr = 3'h0;
    regWdata = 8'h00;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(3'h1, 8'h10);
    rd(3'h0, 8'h00);
    tok(7'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    host_u.signal(0);
    rd(3'h1, 8'h10);
    wr(3'h1, 8'h08);
    repeat (4) @(posedge core_clk);
    wr(3'h2, 8'h03);
    wr(3'h1, 8'h01);
    wr(3'h1, 8'h11);
    rd(3'h1, 8'h01);
    wr(3'h0, 8'h85);
    rd(3'h0, 8'h85);
    tok(7'h05, 1'b0, 1'b0, 1'b0, 1'b0);
    tok(7'h00, 1'b0, 1'b0, 1'b1, 1'b0);
    @(posedge core_clk);
    transferDone <= 1'b1;
    @(posedge core_clk);
    transferDone <= 1'b0;
    rd(3'h0, 8'h05);
    tok(7'h05, 1'b0, 1'b0, 1'b1, 1'b0);
    tok(7'h06, 1'b0, 1'b0, 1'b0, 1'b0);
    wakeSeen = 1'b0;
    host_u.signal(1);
    rd(3'h1, 8'h03);
    chk({7'h00, irqSuspend}, 8'h01);
    host_u.signal(2);
    rd(3'h1, 8'h01);
    chk({7'h00, irqResume}, 8'h01);
    chk({7'h00, wakeSeen}, 8'h01);
    wr(3'h3, 8'h01);
    rd(3'h3, 8'h02);
    wr(3'h1, 8'h05);
    @(negedge core_clk);
    chk({7'h00, driveResume}, 8'h01);
    repeat (20) @(posedge core_clk);
    wr(3'h1, 8'h01);
    @(negedge core_clk);
    chk({7'h00, driveResume}, 8'h00);
    wr(3'h1, 8'h81);
    isoInEndpoint <= 1'b1;
    loadIso(1'b0);
    tok(7'h05, 1'b1, 1'b0, 1'b1, 1'b1);
    tok(7'h00, 1'b0, 1'b1, 1'b1, 1'b0);
    tok(7'h05, 1'b1, 1'b0, 1'b1, 1'b0);
    wr(3'h1, 8'h01);
    loadIso(1'b1);
    isoInEndpoint <= 1'b0;
    wr(3'h4, 8'h02);
    wr(3'h5, 8'h3C);
    rd(3'h5, 8'h3C);
    host_u.signal(0);
    repeat (4) @(posedge core_clk);
    chk({7'h00, flushSeen}, 8'h01);
    chk({7'h00, irqReset}, 8'h01);
    chk({6'h00, irqResume, irqSuspend}, 8'h00);
    rd(3'h1, 8'h09);
    rd(3'h1, 8'h01);
    rd(3'h0, 8'h00);
    rd(3'h2, 8'h0E);
    rd(3'h3, 8'h04);
    rd(3'h4, 8'h00);
    rd(3'h5, 8'h00);
    rd(3'h7, 8'h00);
    tok(7'h05, 1'b0, 1'b0, 1'b0, 1'b0);
    tok(7'h00, 1'b0, 1'b0, 1'b1, 1'b0);
    wr(3'h1, 8'h08);
    repeat (4) @(posedge core_clk);
    rd(3'h1, 8'h10);
    rd(3'h2, 8'h00);
    chk({7'h00, linkEnabled}, 8'h00);
    conclude;
  end
endmodule
